// ===== logic/octal_line_primary_regs.sv
// primary control and status register bank of the octal line front end
`timescale 1ns/1ns
`default_nettype none
`include "octal_line_regs.svh"
module octal_line_primary_regs
	import octal_line_pkg::*;
#(
	parameter logic [7:0] REVISION_WORD = 8'h5A // arbitrary value
) (
	input  wire logic       SYS_CLK_I,
	input  wire logic       NRST_I,
	input  wire logic [3:0] ADDR_I,
	input  wire logic [7:0] WDATA_I,
	input  wire logic       WR_I,
	input  wire logic       RD_I,
	input  wire logic [7:0] ABS_DETECT_I,
	input  wire logic [7:0] FAULT_DETECT_I,
	input  wire logic       T1_MODE_I,
	output logic      [7:0] RDATA_O,
	output logic      [7:0] SEND_ONES_O,
	output logic            LOOPBACK_O,
	output logic      [7:0] RX_MONITOR_O,
	output logic      [7:0] TX_MONITOR_O,
	output logic      [7:0] ETSI_CRIT_O,
	output logic            GUARD_OFF_O,
	output logic            SOFT_RESET_O
);

	localparam logic [6:0] RST_CYC = 7'(`SOFT_RESET_CYC);

	bank_s q;
	bank_s d;

	// one-hot channel select from a 3-bit index, zero index means none
	function automatic logic [7:0] chan_sel(input logic [2:0] idx);
		logic [7:0] v;
		v = 8'h00;
		if (idx != 3'h0) begin
			v[idx] = 1'b1;
		end
		return v;
	endfunction

	function automatic cfg_s cfg_default();
		cfg_s c;
		c = '0;
		return c;
	endfunction

	always_comb begin
		d = q;
		d.rdata = 8'h00;
		// status bits follow the detectors, edges feed the flags
		d.abs_prev = ABS_DETECT_I;
		d.flt_prev = FAULT_DETECT_I;
		case (q.state)
			ST_RUN: begin
				if (RD_I) begin
					case (ADDR_I)
						`OFS_REVISION:   d.rdata = REVISION_WORD;
						`OFS_LOOPBACK:   d.rdata = {7'h00, q.cfg.loopback[0]};
						`OFS_ALL_ONES:   d.rdata = q.cfg.all_ones;
						`OFS_ABS_STATUS: d.rdata = q.abs_prev;
						`OFS_FLT_STATUS: d.rdata = q.flt_prev;
						`OFS_ABS_MASK:   d.rdata = q.cfg.abs_mask;
						`OFS_FLT_MASK:   d.rdata = q.cfg.flt_mask;
						`OFS_ABS_FLAGS:  d.rdata = q.cfg.abs_flags;
						`OFS_FLT_FLAGS:  d.rdata = q.cfg.flt_flags;
						`OFS_SOFT_RESET: d.rdata = `RST_SOFT_RESET;
						`OFS_MONITOR:    d.rdata = {4'h0, q.cfg.monitor};
						`OFS_CRITERION:  d.rdata = q.cfg.criterion;
						`OFS_AUTO_ONES:  d.rdata = q.cfg.auto_ones;
						`OFS_GLOBAL:     d.rdata = q.cfg.global_cfg;
						default:         d.rdata = 8'h00;
					endcase
					// a status read clears the matching flags; a same-cycle edge below sets again
					if (ADDR_I == `OFS_ABS_STATUS) begin
						d.cfg.abs_flags = 8'h00;
					end
					if (ADDR_I == `OFS_FLT_STATUS) begin
						d.cfg.flt_flags = 8'h00;
					end
				end
				if (WR_I) begin
					case (ADDR_I)
						`OFS_LOOPBACK:   d.cfg.loopback = {7'h00, WDATA_I[0]};
						`OFS_ALL_ONES:   d.cfg.all_ones = WDATA_I;
						`OFS_ABS_MASK:   d.cfg.abs_mask = WDATA_I;
						`OFS_FLT_MASK:   d.cfg.flt_mask = WDATA_I;
						`OFS_MONITOR:    d.cfg.monitor = WDATA_I[3:0];
						`OFS_CRITERION:  d.cfg.criterion = WDATA_I;
						`OFS_AUTO_ONES:  d.cfg.auto_ones = WDATA_I;
						`OFS_GLOBAL:     d.cfg.global_cfg = WDATA_I;
						`OFS_SOFT_RESET: begin
							d.state = ST_SOFT_RESET;
							d.rst_cnt = RST_CYC;
						end
						default: begin
						end
					endcase
				end
				// set wins over the read clear
				d.cfg.abs_flags = d.cfg.abs_flags
					| ((ABS_DETECT_I ^ q.abs_prev) & q.cfg.abs_mask);
				d.cfg.flt_flags = d.cfg.flt_flags
					| ((FAULT_DETECT_I ^ q.flt_prev) & q.cfg.flt_mask);
			end
			ST_SOFT_RESET: begin
				// bus ignored during the 100 reset cycles; configuration held at default, status keeps following the detectors
				d.cfg = cfg_default();
				d.rst_cnt = q.rst_cnt - 7'h01;
				if (q.rst_cnt == 7'h01) begin
					d.state = ST_RUN;
				end
			end
			default: d.state = ST_RUN;
		endcase
		if (q.state == ST_SOFT_RESET) begin
			d.cfg = cfg_default();
		end
		// output drive, bit n is channel n
		d.send_ones = d.cfg.all_ones
			| (d.cfg.auto_ones & ABS_DETECT_I);
		d.loop_en = d.cfg.loopback[`POS_LOOPBACK];
		d.rx_mon = d.cfg.monitor[3] ? 8'h00
			: chan_sel(d.cfg.monitor[2:0]);
		d.tx_mon = d.cfg.monitor[3] ? chan_sel(d.cfg.monitor[2:0])
			: 8'h00;
		// criterion is meaningless in T1 mode
		d.e1_etsi = T1_MODE_I ? 8'h00 : d.cfg.criterion;
		d.guard_off = d.cfg.global_cfg[`POS_GUARD_OFF];
	end

	always_ff @(posedge SYS_CLK_I or negedge NRST_I) begin
		if (!NRST_I) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign RDATA_O      = q.rdata;
	assign SEND_ONES_O  = q.send_ones;
	assign LOOPBACK_O   = q.loop_en;
	assign RX_MONITOR_O = q.rx_mon;
	assign TX_MONITOR_O = q.tx_mon;
	assign ETSI_CRIT_O  = q.e1_etsi;
	assign GUARD_OFF_O  = q.guard_off;
	assign SOFT_RESET_O = (q.state == ST_SOFT_RESET);

	chk_revision_read: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(RD_I && ADDR_I == `OFS_REVISION && q.state == ST_RUN) |=> RDATA_O == REVISION_WORD)
		else $error("revision word wrong");
	chk_loopback_follow: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `OFS_LOOPBACK && q.state == ST_RUN) |=> LOOPBACK_O == $past(WDATA_I[0]))
		else $error("loopback not taken");
	chk_all_ones_drive: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `OFS_ALL_ONES && q.state == ST_RUN) |=> (SEND_ONES_O & $past(WDATA_I)) == $past(WDATA_I))
		else $error("all ones missing");
	chk_status_read: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(RD_I && ADDR_I == `OFS_ABS_STATUS && q.state == ST_RUN) ##1 $stable(ABS_DETECT_I) |-> RDATA_O == ABS_DETECT_I)
		else $error("absence status wrong");
	chk_fault_read: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(RD_I && ADDR_I == `OFS_FLT_STATUS && q.state == ST_RUN) ##1 $stable(FAULT_DETECT_I) |-> RDATA_O == FAULT_DETECT_I)
		else $error("fault status wrong");
	chk_abs_mask_block: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(q.cfg.abs_mask == 8'h00 && q.cfg.abs_flags == 8'h00 && q.state == ST_RUN) |=> q.cfg.abs_flags == 8'h00)
		else $error("masked absence flag set");
	chk_flt_mask_block: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(q.cfg.flt_mask == 8'h00 && q.cfg.flt_flags == 8'h00 && q.state == ST_RUN) |=> q.cfg.flt_flags == 8'h00)
		else $error("masked fault flag set");
	chk_abs_flag_set: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(q.state == ST_RUN && !WR_I && |((ABS_DETECT_I ^ q.abs_prev) & q.cfg.abs_mask))
		|=> (q.cfg.abs_flags & $past((ABS_DETECT_I ^ q.abs_prev) & q.cfg.abs_mask)) != 8'h00)
		else $error("absence flag lost");
	chk_flt_flag_set: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(q.state == ST_RUN && !WR_I && |((FAULT_DETECT_I ^ q.flt_prev) & q.cfg.flt_mask))
		|=> (q.cfg.flt_flags & $past((FAULT_DETECT_I ^ q.flt_prev) & q.cfg.flt_mask)) != 8'h00)
		else $error("fault flag lost");
	chk_soft_reset_len: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(WR_I && ADDR_I == `OFS_SOFT_RESET && q.state == ST_RUN) |=> SOFT_RESET_O [*8] ##92 SOFT_RESET_O ##1 !SOFT_RESET_O)
		else $error("soft reset length wrong");
	chk_monitor_idle: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(q.cfg.monitor[2:0] == 3'h0) |=> (RX_MONITOR_O | TX_MONITOR_O) == 8'h00 || $past(WR_I) || $past(q.state != ST_RUN))
		else $error("monitor not idle");
	chk_t1_criterion: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		T1_MODE_I |=> ETSI_CRIT_O == 8'h00)
		else $error("criterion in T1 mode");
	chk_auto_ones: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(q.state == ST_RUN && !WR_I) |=> (SEND_ONES_O & $past(q.cfg.auto_ones & ABS_DETECT_I)) == $past(q.cfg.auto_ones & ABS_DETECT_I))
		else $error("auto all ones missing");
	chk_guard_bit: assert property (@(posedge SYS_CLK_I) disable iff (!NRST_I)
		(q.state == ST_RUN && !WR_I) |=> GUARD_OFF_O == $past(q.cfg.global_cfg[`POS_GUARD_OFF]))
		else $error("guard bit wrong");

endmodule
`default_nettype wire

// ===== pkg/octal_line_pkg.sv
// types shared by the line register bank
package octal_line_pkg;
	typedef enum logic {ST_RUN, ST_SOFT_RESET} bank_state_e;
	typedef struct packed {
		logic [7:0] loopback;
		logic [7:0] all_ones;
		logic [7:0] abs_mask;
		logic [7:0] flt_mask;
		logic [7:0] abs_flags;
		logic [7:0] flt_flags;
		logic [3:0] monitor;
		logic [7:0] criterion;
		logic [7:0] auto_ones;
		logic [7:0] global_cfg;
	} cfg_s;
	typedef struct packed {
		bank_state_e state;
		logic [6:0]  rst_cnt;
		cfg_s        cfg;
		logic [7:0]  abs_prev;
		logic [7:0]  flt_prev;
		logic [7:0]  rdata;
		logic [7:0]  send_ones;
		logic        loop_en;
		logic [7:0]  rx_mon;
		logic [7:0]  tx_mon;
		logic [7:0]  e1_etsi;
		logic        guard_off;
	} bank_s;
endpackage

// ===== pkg/octal_line_regs.svh
// register offsets, reset values and timing counts of the line register bank
`ifndef OCTAL_LINE_REGS_SVH
`define OCTAL_LINE_REGS_SVH
`define OFS_REVISION     4'h0
`define OFS_LOOPBACK     4'h2
`define OFS_ALL_ONES     4'h3
`define OFS_ABS_STATUS   4'h4
`define OFS_FLT_STATUS   4'h5
`define OFS_ABS_MASK     4'h6
`define OFS_FLT_MASK     4'h7
`define OFS_ABS_FLAGS    4'h8
`define OFS_FLT_FLAGS    4'h9
`define OFS_SOFT_RESET   4'hA
`define OFS_MONITOR      4'hB
`define OFS_CRITERION    4'hD
`define OFS_AUTO_ONES    4'hE
`define OFS_GLOBAL       4'hF
`define RST_BYTE         8'h00
`define RST_SOFT_RESET   8'hFF
`define POS_GUARD_OFF    5
`define POS_LOOPBACK     0
`define SOFT_RESET_NS    1000
`define CLK_PERIOD_NS    10
`define SOFT_RESET_CYC   ((`SOFT_RESET_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== verif/octal_line_primary_regs_test.sv
// self-checking bench for the primary line register bank
`timescale 1ns/1ns
`default_nettype none
module octal_line_primary_regs_test;
	localparam logic [7:0] REV = 8'hC3; // arbitrary value
	logic       clk = 1'b0;
	logic       nrst = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] wdata = 8'h00;
	logic       wr_stb = 1'b0;
	logic       rd_stb = 1'b0;
	logic [7:0] abs_det = 8'h00;
	logic [7:0] flt_det = 8'h00;
	logic       t1 = 1'b0;
	logic [7:0] rdata, ones, rx_mon, tx_mon, etsi;
	logic       loop_o, guard_o, srst_o;
	int         errors = 0;
	int         checked = 0;
	int         mreg [16];
	int         n;

	octal_line_primary_regs #(.REVISION_WORD(REV)) dut (
		.SYS_CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
		.WR_I(wr_stb), .RD_I(rd_stb), .ABS_DETECT_I(abs_det),
		.FAULT_DETECT_I(flt_det), .T1_MODE_I(t1), .RDATA_O(rdata),
		.SEND_ONES_O(ones), .LOOPBACK_O(loop_o), .RX_MONITOR_O(rx_mon),
		.TX_MONITOR_O(tx_mon), .ETSI_CRIT_O(etsi), .GUARD_OFF_O(guard_o),
		.SOFT_RESET_O(srst_o)
	);

	always #5 clk = ~clk;

	task automatic cmp(input string what, input logic [7:0] exp,
			input logic [7:0] seen);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// status bytes follow the detectors, so they survive a soft reset
	task automatic model_reset();
		for (int i = 0; i < 16; i++) begin
			if (i != 4 && i != 5) mreg[i] = 0;
		end
		mreg[0] = REV;
		mreg[10] = 8'hFF;
	endtask

	task automatic reg_write(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_stb <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr_stb <= 1'b0;
		case (a)
		4'h2: mreg[2] = d & 8'h01;
		4'h3, 4'h6, 4'h7, 4'hD, 4'hE, 4'hF: mreg[a] = d;
		4'hB: mreg[11] = d & 8'h0F;
		default: ;
		endcase
	endtask

	task automatic reg_read(input logic [3:0] a);
		@(posedge clk);
		rd_stb <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd_stb <= 1'b0;
		#1 cmp($sformatf("register %h", a), 8'(mreg[a]), rdata);
		if (a == 4'h4) mreg[8] = 0;
		if (a == 4'h5) mreg[9] = 0;
	endtask

	// detectors are given two cycles to pass the one-cycle status lag
	task automatic set_det(input logic [7:0] a, input logic [7:0] f);
		@(posedge clk);
		abs_det <= a;
		flt_det <= f;
		mreg[8] |= (mreg[4] ^ a) & mreg[6];
		mreg[9] |= (mreg[5] ^ f) & mreg[7];
		mreg[4] = a;
		mreg[5] = f;
		repeat (2) @(posedge clk);
	endtask

	task automatic chk_outputs();
		int c;
		c = mreg[11];
		@(posedge clk);
		#1;
		cmp("send_ones", 8'(mreg[3] | (mreg[14] & mreg[4])), ones);
		cmp("loopback", {7'h00, mreg[2][0]}, {7'h00, loop_o});
		cmp("guard_off", {7'h00, mreg[15][5]}, {7'h00, guard_o});
		cmp("etsi", t1 ? 8'h00 : 8'(mreg[13]), etsi);
		cmp("rx_mon", (c inside {[1:7]}) ? 8'(1 << c) : 8'h00, rx_mon);
		cmp("tx_mon", (c > 8) ? 8'(1 << (c - 8)) : 8'h00, tx_mon);
	endtask

	initial begin
		#500000;
		errors++;
		report_and_stop();
	end

	initial begin
		model_reset();
		void'($urandom(32'h08EB7A07));
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 15; a >= 0; a--) reg_read(a[3:0]);
		$display("test reset values done");
		// writes reach read-only and unmapped places too; they must not stick
		for (int i = 0; i < 20; i++) begin
			for (int a = 0; a < 16; a++) begin
				if (a == 15) reg_write(4'hF, 8'($urandom) & 8'h20);
				else if (a != 10) reg_write(a[3:0], 8'($urandom));
			end
			set_det(8'($urandom), 8'($urandom));
			t1 <= 1'($urandom);
			chk_outputs();
			for (int a = 15; a >= 0; a--) reg_read(a[3:0]);
		end
		$display("test random configuration done");
		for (int c = 0; c < 16; c++) begin
			reg_write(4'hB, 8'(c) | 8'hF0);
			chk_outputs();
		end
		$display("test monitor codes done");
		reg_write(4'hA, 8'($urandom));
		model_reset();
		n = 0;
		#1;
		while (srst_o === 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		cmp("soft reset length", 8'd100, 8'(n));
		chk_outputs();
		for (int a = 15; a >= 0; a--) reg_read(a[3:0]);
		$display("test soft reset done");
		report_and_stop();
	end
endmodule
`default_nettype wire
